/* File: design/sba_params.svh */
// Offsets, reset values, field positions and codes of the system bus arbiter
`ifndef SBA_PARAMS_SVH
`define SBA_PARAMS_SVH

`define SBA_CTRL_OFFSET     12'h000
`define SBA_STAT_OFFSET     12'h004
`define SBA_CTRL_RESET      32'h0000_0001
`define SBA_CTRL_EN_BIT     0
`define SBA_STAT_OWN_BIT    0
`define SBA_STAT_REQ_BIT    1
`define SBA_STAT_IOM_BIT    2
`define SBA_STAT_RESM_BIT   3
`define SBA_STAT_NEED_BIT   4
`define SBA_STAT_CODE_LSB   8
`define SBA_STAT_CODE_MSB   10

`define SBA_ST_INTA         3'h0
`define SBA_ST_IORD         3'h1
`define SBA_ST_IOWR         3'h2
`define SBA_ST_HALT         3'h3
`define SBA_ST_FETCH        3'h4
`define SBA_ST_MEMRD        3'h5
`define SBA_ST_MEMWR        3'h6
`define SBA_ST_PASSIVE      3'h7

`define SBA_SYNC_W          15

`endif

/* File: design/sba_pkg.sv */
// Types shared by the system bus arbiter
`default_nettype none
package sba_pkg;

  typedef enum logic [2:0] {
    SBA_IDLE = 3'b001,
    SBA_REQ  = 3'b010,
    SBA_OWN  = 3'b100
  } sba_state_t;

  typedef struct packed {
    logic halt;
    logic idle;
    logic io_acc;
    logic mem_acc;
  } sba_status_t;

  typedef struct packed {
    logic bus_clk;
    logic priority_in_n;
    logic bus_held_n;
    logic common_request_line_n;
  } sba_link_in_t;

  typedef struct packed {
    logic bus_request_n;
    logic priority_out_n;
    logic bus_held_o;
    logic bus_held_oe;
    logic common_request_line_o;
    logic common_request_line_oe;
    logic local_buffer_enable_n;
  } sba_link_out_t;

endpackage

`default_nettype wire

/* File: design/sba_arbiter.sv */
// System bus arbiter: status decode, four-mode request logic, daisy-chain arbitration, AHB-Lite registers
`timescale 1ns/100ps
`default_nettype none
`include "sba_params.svh"

module sba_arbiter #(
  parameter int STATUS_W = 3
) (
  input  wire  logic                 clk_in,
  input  wire  logic                 resetn_in,
  input  wire  logic                 proc_clk_in,
  input  wire  logic [STATUS_W-1:0]  processor_status_in,
  input  wire  logic                 lock_n_in,
  input  wire  logic                 common_request_lock_n_in,
  input  wire  logic                 resident_strap_in,
  input  wire  logic                 io_bus_strap_n_in,
  input  wire  logic                 release_any_request_in,
  input  wire  logic                 system_or_local_select_in,
  input  wire  logic                 init_n_in,
  input  wire  sba_pkg::sba_link_in_t link_in,
  output var   sba_pkg::sba_link_out_t link_out,
  input  wire  logic                 hsel_in,
  input  wire  logic [31:0]          haddr_in,
  input  wire  logic [1:0]           htrans_in,
  input  wire  logic                 hwrite_in,
  input  wire  logic [2:0]           hsize_in,
  input  wire  logic [31:0]          hwdata_in,
  input  wire  logic                 hready_in,
  output logic [31:0]                hrdata_out,
  output logic                       hreadyout_out,
  output logic                       hresp_out
);
  import sba_pkg::*;

  if (STATUS_W != 3) begin : g_bad_width
    $error("sba_arbiter: status width must be 3");
  end

  // Reset release through two flops
  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // Every pin except the AHB-Lite ones comes from outside this clock domain
  logic [`SBA_SYNC_W-1:0] raw;
  logic [`SBA_SYNC_W-1:0] sync1_q;
  logic [`SBA_SYNC_W-1:0] sync_q;
  assign raw = {init_n_in, system_or_local_select_in, release_any_request_in, io_bus_strap_n_in,
                resident_strap_in, common_request_lock_n_in, lock_n_in, processor_status_in,
                proc_clk_in, link_in.common_request_line_n, link_in.bus_held_n,
                link_in.priority_in_n, link_in.bus_clk};

  for (genvar i = 0; i < `SBA_SYNC_W; i++) begin : g_sync
    always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
        sync1_q[i] <= 1'b1;
        sync_q[i]  <= 1'b1;
      end else begin
        sync1_q[i] <= raw[i];
        sync_q[i]  <= sync1_q[i];
      end
    end
  end

  logic                bclk_s;
  logic                prio_n_s;
  logic                held_n_s;
  logic                common_request_line_n_s;
  logic                pclk_s;
  logic [2:0]          status_s;
  logic                lock_n_s;
  logic                common_request_lock_n_s;
  logic                res_strap_s;
  logic                iob_strap_n_s;
  logic                any_rq_s;
  logic                sel_s;
  logic                init_n_s;
  assign bclk_s        = sync_q[0];
  assign prio_n_s      = sync_q[1];
  assign held_n_s      = sync_q[2];
  assign common_request_line_n_s      = sync_q[3];
  assign pclk_s        = sync_q[4];
  assign status_s      = sync_q[7:5];
  assign lock_n_s      = sync_q[8];
  assign common_request_lock_n_s    = sync_q[9];
  assign res_strap_s   = sync_q[10];
  assign iob_strap_n_s = sync_q[11];
  assign any_rq_s      = sync_q[12];
  assign sel_s         = sync_q[13];
  assign init_n_s      = sync_q[14];

  // Edge finders on the synchronised clocks
  logic bclk_prev_q;
  logic pclk_prev_q;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bclk_prev_q <= 1'b1;
      pclk_prev_q <= 1'b1;
    end else begin
      bclk_prev_q <= bclk_s;
      pclk_prev_q <= pclk_s;
    end
  end

  logic btick;
  logic ptick;
  assign btick = bclk_prev_q & ~bclk_s;  // Arbitration steps on bus clock fall
  assign ptick = ~pclk_prev_q & pclk_s;  // Status sampled on processor clock rise

  // Mode and status decode
  logic        io_mode;
  logic        res_mode;
  sba_status_t dec;
  logic        need;
  assign io_mode  = ~iob_strap_n_s;
  assign res_mode = res_strap_s;

  always_comb begin
    dec.halt    = (status_s == `SBA_ST_HALT);
    dec.idle    = (status_s == `SBA_ST_PASSIVE);
    dec.io_acc  = (status_s == `SBA_ST_INTA) || (status_s == `SBA_ST_IORD) ||
                  (status_s == `SBA_ST_IOWR);
    dec.mem_acc = (status_s == `SBA_ST_FETCH) || (status_s == `SBA_ST_MEMRD) ||
                  (status_s == `SBA_ST_MEMWR);
    unique case ({io_mode, res_mode})
      2'b00:   need = dec.io_acc | dec.mem_acc;
      2'b10:   need = dec.mem_acc;
      2'b01:   need = (dec.io_acc | dec.mem_acc) & sel_s;
      default: need = dec.mem_acc & sel_s;
    endcase
  end

  sba_status_t st_q;
  logic        need_q;
  logic        local_q;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= '0;
      need_q  <= 1'b0;
      local_q <= 1'b0;
    end else if (ptick) begin
      st_q    <= dec;
      need_q  <= need;
      local_q <= ~sel_s;
    end
  end

  // Software enable gates new requests; a locked processor still requests the bus
  logic [31:0] ctrl_q;
  logic        lock_low;
  logic        hp_req;
  logic        common_request_line_low;
  logic        want;
  logic        common_request_line_cond;
  logic        surrender;
  assign lock_low = ~lock_n_s;
  assign hp_req   = prio_n_s;  // High priority input means a higher board asks
  assign common_request_line_low = ~common_request_line_n_s;
  assign want     = (ctrl_q[`SBA_CTRL_EN_BIT] & need_q) | lock_low;

  always_comb begin
    unique case ({io_mode, res_mode})
      2'b00:   common_request_line_cond = st_q.idle;
      2'b01:   common_request_line_cond = st_q.idle | local_q;
      2'b10:   common_request_line_cond = st_q.idle | st_q.io_acc;
      default: common_request_line_cond = st_q.io_acc | local_q;
    endcase
    // Bus is kept between accesses only in combined mode, unless release-any is set
    // Release-any trades bus retention for fairness: any common request is a surrender cause
    common_request_line_cond = common_request_line_cond | any_rq_s;
    surrender = ~lock_low & (st_q.halt | hp_req |
                             (common_request_line_low & common_request_lock_n_s & common_request_line_cond));
  end

  // Arbitration state
  sba_state_t state_q;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SBA_IDLE;
    end else if (!init_n_s) begin
      state_q <= SBA_IDLE;
    end else if (btick) begin
      unique case (state_q)
        SBA_IDLE: begin
          if (want) begin
            state_q <= SBA_REQ;
          end
        end
        SBA_REQ: begin
          if (!want) begin
            state_q <= SBA_IDLE;
          end else if (!prio_n_s && held_n_s) begin
            // Bus-held line high means nobody owns the bus
            state_q <= SBA_OWN;  // Free bus and no higher requester
          end
        end
        SBA_OWN: begin
          if (surrender) begin
            state_q <= SBA_IDLE;
          end
        end
        default: state_q <= SBA_IDLE;
      endcase
    end
  end

  logic owned;
  logic requesting;
  assign owned      = (state_q == SBA_OWN);
  assign requesting = (state_q != SBA_IDLE);

  // Link outputs, all registered
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      link_out <= '{bus_request_n: 1'b1, priority_out_n: 1'b1, bus_held_o: 1'b0, bus_held_oe: 1'b0,
                    common_request_line_o: 1'b0, common_request_line_oe: 1'b0,
                    local_buffer_enable_n: 1'b1};
    end else begin
      link_out.bus_request_n          <= ~requesting;
      link_out.priority_out_n         <= ~(requesting | hp_req);
      link_out.bus_held_o             <= 1'b0;
      link_out.bus_held_oe            <= owned;
      link_out.common_request_line_o  <= 1'b0;
      link_out.common_request_line_oe <= (state_q == SBA_REQ);
      link_out.local_buffer_enable_n  <= ~owned;
    end
  end

  // AHB-Lite slave, zero wait states
  logic        wr_pend_q;
  logic [11:0] wr_addr_q;
  logic        take;
  logic [31:0] stat_word;
  assign take = hsel_in & htrans_in[1] & hready_in;

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`SBA_STAT_OWN_BIT]  = owned;
    stat_word[`SBA_STAT_REQ_BIT]  = requesting;
    stat_word[`SBA_STAT_IOM_BIT]  = io_mode;
    stat_word[`SBA_STAT_RESM_BIT] = res_mode;
    stat_word[`SBA_STAT_NEED_BIT] = need_q;
    stat_word[`SBA_STAT_CODE_MSB:`SBA_STAT_CODE_LSB] = status_s;
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else if (hready_in) begin
      wr_pend_q <= take & hwrite_in & (haddr_in[31:12] == 20'h00000);
      wr_addr_q <= haddr_in[11:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `SBA_CTRL_RESET;
    end else if (wr_pend_q && wr_addr_q == `SBA_CTRL_OFFSET) begin
      ctrl_q <= {31'h0000_0000, hwdata_in[`SBA_CTRL_EN_BIT]};
    end
  end

  // Read data is prepared in the address phase so it stands for the whole data phase
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_out <= 32'h0000_0000;
    end else if (take && !hwrite_in) begin
      if (haddr_in[11:0] == `SBA_CTRL_OFFSET && haddr_in[31:12] == 20'h00000) begin
        hrdata_out <= ctrl_q;
      end else if (haddr_in[11:0] == `SBA_STAT_OFFSET && haddr_in[31:12] == 20'h00000) begin
        hrdata_out <= stat_word;
      end else begin
        hrdata_out <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_tick_owned;
    btick && owned && init_n_s;
  endsequence

  sequence s_grant_seen;
    btick && state_q == SBA_REQ && want && !prio_n_s && held_n_s && init_n_s;
  endsequence

  sequence s_common_request_line_armed;
    !lock_low && common_request_lock_n_s && common_request_line_low;
  endsequence

  chk_grant_cond: assert property ($rose(owned) |-> $past(!prio_n_s && held_n_s && btick))
    else $error("ownership taken without free bus and grant");
  chk_grant_take: assert property (s_grant_seen |=> owned)
    else $error("grant conditions met but bus not taken");
  chk_lock_hold: assert property (s_tick_owned ##0 lock_low |=> owned)
    else $error("bus released while locked");
  chk_halt_drop: assert property (s_tick_owned ##0 (!lock_low && st_q.halt) |=> state_q == SBA_IDLE)
    else $error("bus kept on halt");
  chk_common_request_lock_keep: assert property (s_tick_owned ##0 (!lock_low && !common_request_lock_n_s && !st_q.halt && !hp_req)
                                    |=> owned)
    else $error("common request surrender under request lock");
  chk_init_clear: assert property (!init_n_s |=> state_q == SBA_IDLE ##1 link_out.local_buffer_enable_n)
    else $error("init did not clear ownership");
  chk_held_drive: assert property (owned |=> link_out.bus_held_oe && !link_out.local_buffer_enable_n)
    else $error("bus-held or buffer enable wrong while owning");
  chk_common_request_line_drive: assert property ((state_q == SBA_REQ) |=> link_out.common_request_line_oe
                                   && !link_out.bus_request_n)
    else $error("common request not driven while requesting");
  chk_prio_out: assert property (hp_req |=> !link_out.priority_out_n)
    else $error("priority output high with higher request");
  chk_halt_noreq: assert property (ptick && status_s == `SBA_ST_HALT |=> !need_q)
    else $error("request decoded for halt status");
  chk_iomode_noio: assert property (ptick && io_mode && !res_mode && dec.io_acc |=> !need_q)
    else $error("I/O mode requested for an I/O cycle");
  chk_res_local: assert property (ptick && !io_mode && res_mode && !sel_s |=> !need_q)
    else $error("resident mode requested a local access");
  chk_comb_memonly: assert property (ptick && io_mode && res_mode && !dec.mem_acc |=> !need_q)
    else $error("combined mode requested a non-memory cycle");
  chk_anyrq_drop: assert property (s_tick_owned ##0 s_common_request_line_armed ##0 any_rq_s |=> state_q == SBA_IDLE)
    else $error("bus kept on common request with release-any set");
  chk_single_idle: assert property (s_tick_owned ##0 s_common_request_line_armed ##0 (st_q.idle && !io_mode && !res_mode)
                                    |=> state_q == SBA_IDLE)
    else $error("single mode kept bus while idle on common request");
  chk_req_drive: assert property (!requesting |=> link_out.bus_request_n)
    else $error("bus request driven while idle");
  chk_prio_idle: assert property (!requesting && !hp_req |=> link_out.priority_out_n)
    else $error("priority output low with no request in the chain");

endmodule

`default_nettype wire

/* File: verif/sba_far_end.sv */
// Far-side model: the other arbiters on the shared bus and the pulled-up shared wires
`timescale 1ns/100ps
`default_nettype none
module sba_far_end (
  input  wire logic                   other_hold_in,
  input  wire logic                   other_req_in,
  input  wire logic                   higher_req_in,
  input  wire sba_pkg::sba_link_out_t link_out_in,
  output var  sba_pkg::sba_link_in_t  link_in_out
);
  import sba_pkg::*;
  logic bclk;
  logic hold_q;
  logic req_q;
  logic hp_q;
  // The arbitration clock runs free on the backplane, so it is not gated between transfers
  initial begin
    bclk = 1'b1;
    hold_q = 1'b0;
    req_q = 1'b0;
    hp_q = 1'b0;
    forever #80 bclk = ~bclk;
  end
  // Commands change on the rising edge, half a period clear of the falling sample edge
  always @(posedge bclk) begin
    hold_q <= other_hold_in;
    req_q <= other_req_in;
    hp_q <= higher_req_in;
  end
  always_comb begin
    link_in_out.bus_clk = bclk;
    link_in_out.priority_in_n = hp_q;
    link_in_out.bus_held_n = ~(hold_q | (link_out_in.bus_held_oe & ~link_out_in.bus_held_o));
    link_in_out.common_request_line_n = ~(req_q | (link_out_in.common_request_line_oe
                                                   & ~link_out_in.common_request_line_o));
  end
endmodule
`default_nettype wire

/* File: verif/tb_system_bus_arbiter.sv */
// Self-checking bench for the system bus arbiter
`timescale 1ns/100ps
`default_nettype none
`include "sba_params.svh"
module tb_system_bus_arbiter;
  import sba_pkg::*;
  logic          clk_in, resetn_in, proc_clk, lock_n, crql_n, res_s, iob_n, rel_any, sel, init_n;
  logic          hold, oreq, hp, hsel, hwrite, hreadyout, hresp, exp;
  logic [2:0]    status, hsize;
  logic [1:0]    htrans;
  logic [31:0]   haddr, hwdata, hrdata, rd;
  logic [16:0]   lfsr;
  logic [10:0]   row;
  sba_link_in_t  li;
  sba_link_out_t lo;
  int            miscompares, checks_done;
  // Row: iob_n, resident, status after ownership, lock_n, crql_n, release-any, common_request_line, higher, keep
  localparam logic [10:0] ROWS [10] = '{11'b10_111_1100_0_1, 11'b10_111_1101_0_0, 11'b10_111_0101_1_1,
    11'b10_011_1100_0_0, 11'b10_101_1100_1_0, 11'b10_111_1001_0_1, 11'b01_111_1101_0_1,
    11'b01_111_1111_0_0, 11'b00_001_1101_0_0, 11'b11_111_1101_0_0};

  sba_arbiter dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .proc_clk_in(proc_clk),
    .processor_status_in(status), .lock_n_in(lock_n), .common_request_lock_n_in(crql_n),
    .resident_strap_in(res_s), .io_bus_strap_n_in(iob_n), .release_any_request_in(rel_any),
    .system_or_local_select_in(sel), .init_n_in(init_n), .link_in(li), .link_out(lo), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp));
  sba_far_end far_u (.other_hold_in(hold), .other_req_in(oreq), .higher_req_in(hp),
    .link_out_in(lo), .link_in_out(li));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    proc_clk = 1'b0;
    forever #100 proc_clk = ~proc_clk;
  end

  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  function automatic logic want_bus(input logic io_n, input logic res, input logic [2:0] st, input logic sl);
    logic acc;
    acc = (st != `SBA_ST_HALT) && (st != `SBA_ST_PASSIVE);
    case ({io_n, res})
      2'b10: return acc;
      2'b11: return acc && sl;
      2'b00: return acc && st[2];
      default: return acc && st[2] && sl;
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Starts one edge late so that back-to-back calls never assign htrans twice in a step
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk_in); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_in); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic grab(input logic io_n, input logic res);
    init_n <= 1'b0;
    lock_n <= 1'b1;
    crql_n <= 1'b1;
    rel_any <= 1'b0;
    oreq <= 1'b0;
    hp <= 1'b0;
    hold <= 1'b0;
    tick(48);
    check(lo.local_buffer_enable_n, 1'b1);
    init_n <= 1'b1;
    iob_n <= io_n;
    res_s <= res;
    sel <= 1'b1;
    status <= `SBA_ST_MEMRD;
    for (int n = 0; n < 200 && lo.local_buffer_enable_n !== 1'b0; n++) @(posedge clk_in);
    tick(2);
    check(lo.local_buffer_enable_n, 1'b0);
    check(li.bus_held_n, 1'b0);
    check(lo.bus_request_n, 1'b0);
    ahb(1'b0, {20'h0, `SBA_STAT_OFFSET}, 32'h0, rd);
    check(rd[`SBA_STAT_OWN_BIT], 1'b1);
    check(rd[`SBA_STAT_IOM_BIT], !io_n);
    check(rd[`SBA_STAT_RESM_BIT], res);
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_in);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    {resetn_in, lock_n, crql_n, res_s, iob_n, rel_any, sel, init_n} = 8'h69;
    {hold, oreq, hp, hwrite} = 4'h0;
    hsel = 1'b1;
    htrans = 2'b00;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    status = `SBA_ST_PASSIVE;
    lfsr = 17'h145b0;
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    tick(3);
    check(lo.bus_request_n, 1'b1);
    ahb(1'b0, {20'h0, `SBA_CTRL_OFFSET}, 32'h0, rd);
    check(rd, `SBA_CTRL_RESET);
    lfsr = lfsr_next(lfsr);
    ahb(1'b1, {20'h0, `SBA_CTRL_OFFSET}, {15'h0, lfsr}, rd);
    ahb(1'b0, {20'h0, `SBA_CTRL_OFFSET}, 32'h0, rd);
    check(rd[0], lfsr[0]);
    ahb(1'b0, 32'h8, 32'h0, rd);
    check(rd, 32'h0);
    check(hresp, 1'b0);
    ahb(1'b1, {20'h0, `SBA_CTRL_OFFSET}, 32'h1, rd);
    // Another board owns the bus, so the request level can be read without a grant hiding it
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 16; s++) begin
        lfsr = lfsr_next(lfsr);
        hold <= 1'b1;
        init_n <= 1'b0;
        rel_any <= lfsr[0];
        crql_n <= lfsr[1];
        tick(48);
        init_n <= 1'b1;
        {iob_n, res_s} <= m[1:0];
        {sel, status} <= s[3:0];
        tick(48);
        exp = want_bus(m[1], m[0], s[2:0], s[3]);
        check(lo.bus_request_n, !exp);
        check(lo.priority_out_n, !exp);
        check(li.common_request_line_n, !exp);
        check(lo.local_buffer_enable_n, 1'b1);
      end
    end
    foreach (ROWS[i]) begin
      row = ROWS[i];
      grab(row[10], row[9]);
      status <= row[8:6];
      lock_n <= row[5];
      crql_n <= row[4];
      rel_any <= row[3];
      oreq <= row[2];
      hp <= row[1];
      tick(64);
      check(lo.local_buffer_enable_n, !row[0]);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
